/* File: core/dio_top.sv */
// Dual 8-bit GPIO port with the shared active-low reset pin.
// Assumes CLK at 250 MHz, RESET_PIN_ACTIVE_LOW is the pin reset already conditioned,
// and the board resolves pad levels from the output enables.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
module dio_top
  import dio_pkg::*;
#(
  parameter int STAB_CYC = STAB_CYC_DEF
)(
  input  wire logic       CLK,
  input  wire logic       RESET_PIN_ACTIVE_LOW,
  input  wire logic       CE,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic [7:0] P0_I,
  output logic      [7:0] P0_O,
  output logic      [7:0] P0_OE_N,
  output logic      [7:0] P0_PU,
  input  wire logic [7:0] P1_I,
  output logic      [7:0] P1_O,
  output logic      [7:0] P1_OE_N,
  output logic      [7:0] P1_PU,
  input  wire logic       RESET_PIN_I,
  output logic            RESET_PIN_O,
  output logic            RESET_PIN_OE_N,
  output logic            CORE_RUN
);
  typedef enum logic [2:0] {
    ST_STAB = 3'h1,
    ST_RUN  = 3'h2,
    ST_PULL = 3'h4
  } dio_state_t;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // One configuration bundle per port, shared with its pad slice
  dio_cfg_if cfg0 ();
  dio_cfg_if cfg1 ();

  // Software-visible port registers
  logic [7:0]       p0_data_ff;
  logic [7:0]       p0_dir_ff;
  logic [7:0]       p0_plu_ff;
  logic [7:0]       p1_data_ff;
  logic [7:0]       p1_dir_ff;
  logic [7:0]       p1_plu_ff;
  logic             shared_ff;
  logic [7:0]       nxt_p0_data;
  logic [7:0]       nxt_p0_dir;
  logic [7:0]       nxt_p0_plu;
  logic [7:0]       nxt_p1_data;
  logic [7:0]       nxt_p1_dir;
  logic [7:0]       nxt_p1_plu;
  logic             nxt_shared;

  // Registered read data
  logic [7:0]       rdata_ff;
  logic [7:0]       nxt_rdata;

  // Reset sequencer
  dio_state_t       state_ff;
  dio_state_t       nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;

  // Reset pin synchroniser
  logic             rpin_s1_ff;
  logic             rpin_s2_ff;
  logic             nxt_rpin_s1;
  logic             nxt_rpin_s2;

  // Qualified bus strobes
  logic             wr_en;
  logic             swrst_req;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Write hit on a given offset
  function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] target);
    wr_hit = (a == target);
  endfunction : wr_hit

  // Input bits show the pin, output bits the stored data
  // Output bits read back the register, not the pad, by choice
  function automatic logic [7:0] port_view(input logic [7:0] dir,
                                           input logic [7:0] data,
                                           input logic [7:0] pin);
    port_view = (dir & data) | (~dir & pin);
  endfunction : port_view

  // ----------------------------------------------------------------
  // Pad instances
  // ----------------------------------------------------------------
  assign cfg0.out_val = p0_data_ff;
  assign cfg0.dir     = p0_dir_ff;
  assign cfg0.plu     = p0_plu_ff;
  assign cfg0.pin_raw = P0_I;
  assign cfg1.out_val = p1_data_ff;
  assign cfg1.dir     = p1_dir_ff;
  assign cfg1.plu     = p1_plu_ff;
  assign cfg1.pin_raw = P1_I;

  // Pads own the pin synchronisers; configuration stays here
  dio_pad8 u_pad0 (.CLK(CLK), .RESET_PIN_ACTIVE_LOW(RESET_PIN_ACTIVE_LOW), .CE(CE), .cfg(cfg0));
  dio_pad8 u_pad1 (.CLK(CLK), .RESET_PIN_ACTIVE_LOW(RESET_PIN_ACTIVE_LOW), .CE(CE), .cfg(cfg1));

  assign P0_O    = cfg0.drv_o;
  assign P0_OE_N = cfg0.drv_oe_n;
  assign P0_PU   = cfg0.pull_en;
  assign P1_O    = cfg1.drv_o;
  assign P1_OE_N = cfg1.drv_oe_n;
  assign P1_PU   = cfg1.pull_en;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Writes only land while running and enabled; no soft state changes mid-pull
  assign wr_en     = CE && WR && (state_ff == ST_RUN);
  assign swrst_req = wr_en && wr_hit(ADDR, ADDR_SWRST) && WDATA[SWRST_GO_BIT];

  // Hold by default; unmapped offsets fall through untouched
  always_comb begin
    nxt_p0_data = p0_data_ff;
    nxt_p0_dir  = p0_dir_ff;
    nxt_p0_plu  = p0_plu_ff;
    nxt_p1_data = p1_data_ff;
    nxt_p1_dir  = p1_dir_ff;
    nxt_p1_plu  = p1_plu_ff;
    nxt_shared  = shared_ff;
    if (wr_en) begin
      if (wr_hit(ADDR, ADDR_P0_DATA)) nxt_p0_data = WDATA;
      if (wr_hit(ADDR, ADDR_P0_DIR))  nxt_p0_dir  = WDATA;
      if (wr_hit(ADDR, ADDR_P0_PLU))  nxt_p0_plu  = WDATA;
      if (wr_hit(ADDR, ADDR_P1_DATA)) nxt_p1_data = WDATA;
      if (wr_hit(ADDR, ADDR_P1_DIR))  nxt_p1_dir  = WDATA;
      if (wr_hit(ADDR, ADDR_P1_PLU))  nxt_p1_plu  = WDATA;
      if (wr_hit(ADDR, ADDR_P2_DATA)) nxt_shared  = WDATA[SHARED_BIT];
    end
  end

  // All inputs, pull-ups off after pin reset
  // Data clears too, so a bit turned to output later starts low
  always_ff @(posedge CLK or negedge RESET_PIN_ACTIVE_LOW) begin
    if (!RESET_PIN_ACTIVE_LOW) begin
      p0_data_ff <= RST_BYTE;
      p0_dir_ff  <= RST_BYTE;
      p0_plu_ff  <= RST_BYTE;
      p1_data_ff <= RST_BYTE;
      p1_dir_ff  <= RST_BYTE;
      p1_plu_ff  <= RST_BYTE;
      shared_ff  <= RST_SHARED[SHARED_BIT];
    end else begin
      p0_data_ff <= nxt_p0_data;
      p0_dir_ff  <= nxt_p0_dir;
      p0_plu_ff  <= nxt_p0_plu;
      p1_data_ff <= nxt_p1_data;
      p1_dir_ff  <= nxt_p1_dir;
      p1_plu_ff  <= nxt_p1_plu;
      shared_ff  <= nxt_shared;
    end
  end

  // ----------------------------------------------------------------
  // Read path, data one cycle after the strobe
  // ----------------------------------------------------------------
  // Reads work during the stabilise wait, so software can poll status;
  // an idle slot with CE high clears; with CE low the last read data hold on the bus
  always_comb begin
    nxt_rdata = RST_BYTE;
    if (!CE) begin
      nxt_rdata = rdata_ff;
    end else if (RD) begin
      unique case (ADDR)
        ADDR_P0_DATA: nxt_rdata = port_view(p0_dir_ff, p0_data_ff, cfg0.pin_sync);
        ADDR_P0_DIR:  nxt_rdata = p0_dir_ff;
        ADDR_P0_PLU:  nxt_rdata = p0_plu_ff;
        ADDR_P1_DATA: nxt_rdata = port_view(p1_dir_ff, p1_data_ff, cfg1.pin_sync);
        ADDR_P1_DIR:  nxt_rdata = p1_dir_ff;
        ADDR_P1_PLU:  nxt_rdata = p1_plu_ff;
        ADDR_P2_DATA: begin
          nxt_rdata             = RST_BYTE;
          nxt_rdata[SHARED_BIT] = rpin_s2_ff;
        end
        ADDR_STATUS: begin
          nxt_rdata               = RST_BYTE;
          nxt_rdata[ST_RUN_BIT]   = (state_ff == ST_RUN);
          nxt_rdata[ST_SWRST_BIT] = (state_ff == ST_PULL);
          nxt_rdata[ST_PIN_BIT]   = shared_ff;
        end
        default:      nxt_rdata = RST_BYTE;   // Unmapped reads zero
      endcase
    end
  end

  // Read slot register
  always_ff @(posedge CLK or negedge RESET_PIN_ACTIVE_LOW) begin
    if (!RESET_PIN_ACTIVE_LOW) begin
      rdata_ff <= RST_BYTE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign RDATA = rdata_ff;

  // ----------------------------------------------------------------
  // Reset pin sampling
  // ----------------------------------------------------------------
  // Pin idles high on its pull-up; resetting the flops high avoids
  // a false low reading in the first cycles after reset
  always_comb begin
    nxt_rpin_s1 = CE ? RESET_PIN_I : rpin_s1_ff;
    nxt_rpin_s2 = CE ? rpin_s1_ff : rpin_s2_ff;
  end

  // Two flops before the read path sees the pin
  always_ff @(posedge CLK or negedge RESET_PIN_ACTIVE_LOW) begin
    if (!RESET_PIN_ACTIVE_LOW) begin
      rpin_s1_ff <= RST_SHARED[SHARED_BIT];
      rpin_s2_ff <= RST_SHARED[SHARED_BIT];
    end else begin
      rpin_s1_ff <= nxt_rpin_s1;
      rpin_s2_ff <= nxt_rpin_s2;
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  // Stabilise wait, then run; soft reset pulls the pin for a while.
  // The pulled pin asserts RESET_PIN_ACTIVE_LOW itself, which restarts everything.
  // CE low freezes the count, so the wait stretches with the enable.
  // A request with the shared bit still high is dropped silently.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    if (CE) begin
      unique case (state_ff)
        ST_STAB: begin
          if (cnt_ff >= CNT_W'(STAB_CYC - 1)) begin
            nxt_state = ST_RUN;
            nxt_cnt   = '0;
          end else begin
            nxt_cnt = cnt_ff + 1'b1;
          end
        end
        ST_RUN: begin
          if (swrst_req && !shared_ff) begin
            nxt_state = ST_PULL;
            nxt_cnt   = '0;
          end
        end
        ST_PULL: begin
          // Fallback end if the board never feeds the pin back
          if (cnt_ff >= CNT_W'(SWRST_CYC - 1)) begin
            nxt_state = ST_STAB;
            nxt_cnt   = '0;
          end else begin
            nxt_cnt = cnt_ff + 1'b1;
          end
        end
        default: begin
          nxt_state = ST_STAB;
          nxt_cnt   = '0;
        end
      endcase
    end
  end

  // Pin reset restarts the stabilise wait
  always_ff @(posedge CLK or negedge RESET_PIN_ACTIVE_LOW) begin
    if (!RESET_PIN_ACTIVE_LOW) begin
      state_ff <= ST_STAB;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Open drain: output level always low, enable only while pulling
  // Never drives high; the board pull-up gives the released level
  assign RESET_PIN_O    = 1'b0;
  assign RESET_PIN_OE_N = (state_ff != ST_PULL);
  assign CORE_RUN       = (state_ff == ST_RUN);
endmodule : dio_top

/* File: include/dio_pkg.sv */
// Package for the dual I/O port with shared reset pin.
// Assumes a single 250 MHz clock domain and an 8-bit register port.
package dio_pkg;
  // ----------------------------------------------------------------
  // Register offsets (plain port, byte index)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_P0_DATA   = 4'h0;
  localparam logic [3:0] ADDR_P0_DIR    = 4'h1;
  localparam logic [3:0] ADDR_P0_PLU    = 4'h2;
  localparam logic [3:0] ADDR_P1_DATA   = 4'h3;
  localparam logic [3:0] ADDR_P1_DIR    = 4'h4;
  localparam logic [3:0] ADDR_P1_PLU    = 4'h5;
  localparam logic [3:0] ADDR_P2_DATA   = 4'h6;
  localparam logic [3:0] ADDR_SWRST     = 4'h7;
  localparam logic [3:0] ADDR_STATUS    = 4'h8;
  // ----------------------------------------------------------------
  // Widths, reset values, field positions
  // ----------------------------------------------------------------
  localparam int         PORT_W         = 8;
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] RST_SHARED     = 8'h80;
  localparam int         SHARED_BIT     = 7;
  localparam int         SWRST_GO_BIT   = 0;
  localparam int         ST_RUN_BIT     = 0;
  localparam int         ST_SWRST_BIT   = 1;
  localparam int         ST_PIN_BIT     = 2;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         CLK_MHZ        = 250;
  localparam int         SWRST_PULSE_NS = 1000;
  localparam int         SWRST_CYC      = (SWRST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int         STAB_CYC_DEF   = 16384;
  localparam int         CNT_W          = 16;
endpackage : dio_pkg

/* File: include/dio_cfg_if.sv */
// Interface carrying port configuration from the register file to the pads.
// Assumes both ends run on the same clock.
interface dio_cfg_if;
  logic [7:0] out_val;
  logic [7:0] dir;
  logic [7:0] plu;
  logic [7:0] pin_sync;
  logic [7:0] pin_raw;
  logic [7:0] drv_oe_n;
  logic [7:0] drv_o;
  logic [7:0] pull_en;
  modport regs (output out_val, output dir, output plu, input pin_sync);
  modport pads (input out_val, input dir, input plu, output pin_sync,
                input pin_raw, output drv_oe_n, output drv_o, output pull_en);
endinterface : dio_cfg_if

/* File: core/dio_pad8.sv */
// One 8-bit tri-state port: drivers, pull-ups and input synchroniser.
// Assumes the interface supplies raw pin levels from outside the domain.
module dio_pad8
  import dio_pkg::*;
(
  input  wire logic CLK,
  input  wire logic RESET_PIN_ACTIVE_LOW,
  input  wire logic CE,
  dio_cfg_if.pads   cfg
);
  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;
  logic [7:0] nxt_sync1;
  logic [7:0] nxt_sync2;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  // Two stages before anything reads the pin
  always_comb begin
    nxt_sync1 = CE ? cfg.pin_raw : sync1_ff;
    nxt_sync2 = CE ? sync1_ff : sync2_ff;
  end

  always_ff @(posedge CLK or negedge RESET_PIN_ACTIVE_LOW) begin
    if (!RESET_PIN_ACTIVE_LOW) begin
      sync1_ff <= RST_BYTE;
      sync2_ff <= RST_BYTE;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  // Direction 1 drives stored data, 0 floats; pull-up only when selected
  assign cfg.drv_o    = cfg.out_val;
  assign cfg.drv_oe_n = ~cfg.dir;
  assign cfg.pull_en  = cfg.plu;
  assign cfg.pin_sync = sync2_ff;
endmodule : dio_pad8

/* File: verification/dio_chk_assertions.sv */
// Concurrent checks on the ports of dio_top.
// Assumes CE never drops right after a read; bound from the bench top file.
module dio_chk
  import dio_pkg::*;
#(parameter int STAB_CYC = 8)(
  input wire logic       CLK,
  input wire logic       RESET_PIN_ACTIVE_LOW,
  input wire logic       CE,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic [7:0] P0_O,
  input wire logic [7:0] P0_OE_N,
  input wire logic [7:0] P0_PU,
  input wire logic [7:0] P1_OE_N,
  input wire logic [7:0] P1_PU,
  input wire logic       RESET_PIN_O,
  input wire logic       RESET_PIN_OE_N,
  input wire logic       CORE_RUN
);
  timeunit 1ns / 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_PIN_ACTIVE_LOW);
  logic        sw_ff;
  logic [15:0] low_ff;
  wire         wok = WR && CE && CORE_RUN;
  // Soft reset request seen, and how long CORE_RUN has been low
  always_ff @(posedge CLK or negedge RESET_PIN_ACTIVE_LOW) begin
    if (!RESET_PIN_ACTIVE_LOW) begin
      sw_ff  <= 1'b0;
      low_ff <= 16'h0000;
    end else begin
      sw_ff  <= wok && ADDR == ADDR_SWRST && WDATA[SWRST_GO_BIT];
      low_ff <= CORE_RUN ? 16'h0000 : low_ff + 16'h0001;
    end
  end
  a_reset_idle: assert property (disable iff (1'b0) !RESET_PIN_ACTIVE_LOW |->
    (P0_OE_N & P1_OE_N) == 8'hFF && (P0_PU | P1_PU) == 8'h00 && RESET_PIN_OE_N && !CORE_RUN)
    else $error("outputs not idle in reset");
  a_p0_dir: assert property (wok && ADDR == ADDR_P0_DIR |=>
    P0_OE_N == ~$past(WDATA)) else $error("port 0 direction lost");
  a_p0_pull: assert property (wok && ADDR == ADDR_P0_PLU |=>
    P0_PU == $past(WDATA)) else $error("port 0 pull-up lost");
  a_p1_dir: assert property (wok && ADDR == ADDR_P1_DIR |=>
    P1_OE_N == ~$past(WDATA)) else $error("port 1 direction lost");
  a_p1_pull: assert property (wok && ADDR == ADDR_P1_PLU |=>
    P1_PU == $past(WDATA)) else $error("port 1 pull-up lost");
  a_p0_data: assert property (wok && ADDR == ADDR_P0_DATA |=>
    P0_O == $past(WDATA)) else $error("port 0 data lost");
  a_rdata_quiet: assert property (!$past(RD) |->
    RDATA == 8'h00) else $error("read data outside its slot");
  a_pin_low_only: assert property (RESET_PIN_O == 1'b0)
    else $error("reset pin driven high");
  a_pull_cause: assert property ($fell(RESET_PIN_OE_N) |->
    sw_ff) else $error("reset pin pulled without request");
  a_run_wait: assert property ($rose(CORE_RUN) |->
    low_ff >= STAB_CYC) else $error("run before stabilise wait");
endmodule : dio_chk

/* File: verification/dio_board.sv */
// Board model for one 8-bit port: drivers, pull-ups and outside sources.
// Assumes the bench says which input bits an outside source drives.
module dio_board (
  input  wire logic       clk,
  input  wire logic [7:0] oe_n,
  input  wire logic [7:0] o,
  input  wire logic [7:0] pu,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_v,
  output logic      [7:0] pin
);
  timeunit 1ns / 1ns;
  logic tgl = 1'b0;
  // Floating pins toggle, so a stale level never reads back as valid
  always @(posedge clk) tgl <= ~tgl;
  // Clock source never stops; no stop or slow mode exists here
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin[i] = !oe_n[i] ? o[i] : ext_en[i] ? ext_v[i] : pu[i] ? 1'b1 : tgl;
    end
  end
endmodule : dio_board

/* File: verification/dio_top_bench.sv */
// Self-checking bench for dio_top with one board model per port.
// Assumes dio_chk and dio_board are compiled before this file.
module dio_top_bench
  import dio_pkg::*;
;
  timeunit 1ns / 1ns;
  localparam int STAB_CYC = 8;
  logic       clk = 1'b0, reset_pin_active_low = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [7:0] p_o[2], p_oe_n[2], p_pu[2], p_i[2];
  logic [7:0] ext_en[2] = '{8'h00, 8'h00}, ext_v[2] = '{8'h00, 8'h00};
  logic       rp_o, rp_oe_n, rp_i, run;
  logic [7:0] expq[$];
  int         seed = 21872, checks = 0, failures = 0, cyc_n = 0;
  dio_top #(.STAB_CYC(STAB_CYC)) u_dio_top (
    .CLK(clk), .RESET_PIN_ACTIVE_LOW(reset_pin_active_low), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .P0_I(p_i[0]), .P0_O(p_o[0]), .P0_OE_N(p_oe_n[0]), .P0_PU(p_pu[0]),
    .P1_I(p_i[1]), .P1_O(p_o[1]), .P1_OE_N(p_oe_n[1]), .P1_PU(p_pu[1]),
    .RESET_PIN_I(rp_i), .RESET_PIN_O(rp_o), .RESET_PIN_OE_N(rp_oe_n), .CORE_RUN(run));
  for (genvar g = 0; g < 2; g++) begin : g_board
    dio_board u_dio_board (.clk(clk), .oe_n(p_oe_n[g]), .o(p_o[g]), .pu(p_pu[g]),
      .ext_en(ext_en[g]), .ext_v(ext_v[g]), .pin(p_i[g]));
  end
  // Board pull-up on the reset pin; the device may only pull it low
  assign rp_i = rp_oe_n ? 1'b1 : rp_o;
  initial forever #2 clk = ~clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) rd_q <= rd && ce;
  always @(negedge clk) if (rd_q) chk(rdata, expq.pop_front());
  // Hang guard, well above the expected run of about five hundred cycles
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      failures++;
      end_of_test();
    end
  end
  // One bus cycle; for a read, d is the value expected back
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    if (r) expq.push_back(d);
  endtask : bus
  task automatic cyc(input int n);
    repeat (n) bus(1'b0, 1'b0, 4'h0, 8'h00);
  endtask : cyc
  task automatic do_reset;
    @(posedge clk);
    reset_pin_active_low <= 1'b0;
    cyc(16);
    @(negedge clk);
    chk(p_oe_n[0] & p_oe_n[1], 8'hFF);
    chk(p_pu[0] | p_pu[1], 8'h00);
    chk({rp_oe_n, run}, 8'h02);
    @(posedge clk);
    reset_pin_active_low <= 1'b1;
  endtask : do_reset
  task automatic wait_run;
    for (int k = 0; k < 64 && run !== 1'b1; k++) cyc(1);
    @(negedge clk);
    chk(run, 1'b1);
  endtask : wait_run
  // Main sequence
  initial begin
    logic [7:0] dir, pu, dat, ev;
    logic [3:0] b;
    int         n;
    do_reset();
    bus(1'b1, 1'b0, ADDR_P0_DIR, 8'hFF);
    @(negedge clk);
    chk(run, 1'b0);
    wait_run();
    bus(1'b0, 1'b1, ADDR_P0_DIR, 8'h00);
    bus(1'b0, 1'b1, ADDR_P1_PLU, 8'h00);
    bus(1'b0, 1'b1, ADDR_SWRST, 8'h00);
    bus(1'b1, 1'b0, 4'hF, 8'hFF);
    bus(1'b0, 1'b1, 4'hF, 8'h00);
    bus(1'b0, 1'b1, ADDR_STATUS, 8'h05);
    bus(1'b0, 1'b1, ADDR_P2_DATA, 8'h80);
    cyc(1);
    // Enable low: a write must not land while frozen
    bus(1'b1, 1'b0, ADDR_P0_DIR, 8'hAA);
    ce <= 1'b0;
    cyc(3);
    ce <= 1'b1;
    @(negedge clk);
    chk(p_oe_n[0], 8'hFF);
    bus(1'b0, 1'b1, ADDR_P0_DIR, 8'h00);
    for (int k = 0; k < 16; k++) begin
      b = 4'(3 * (k % 2));
      dir = 8'($random(seed));
      pu = 8'($random(seed));
      dat = 8'($random(seed));
      ev = 8'($random(seed));
      bus(1'b1, 1'b0, b, dat);
      ext_en[k % 2] <= ~dir & ~pu;
      ext_v[k % 2] <= ev;
      bus(1'b1, 1'b0, b + 4'h1, dir);
      bus(1'b1, 1'b0, b + 4'h2, pu);
      cyc(4);
      @(negedge clk);
      chk(p_oe_n[k % 2], ~dir);
      chk(p_pu[k % 2], pu);
      chk(p_o[k % 2], dat);
      bus(1'b0, 1'b1, b, (dat & dir) | (~dir & (pu | ev)));
      bus(1'b0, 1'b1, b + 4'h1, dir);
    end
    // Shared bit still high from reset, so the pin must stay released
    bus(1'b1, 1'b0, ADDR_SWRST, 8'h01);
    cyc(2);
    @(negedge clk);
    chk(rp_oe_n, 1'b1);
    wait_run();
    bus(1'b1, 1'b0, ADDR_P2_DATA, 8'h00);
    bus(1'b1, 1'b0, ADDR_SWRST, 8'h01);
    bus(1'b0, 1'b1, ADDR_STATUS, 8'h02);
    cyc(1);
    bus(1'b0, 1'b1, ADDR_P2_DATA, 8'h00);
    cyc(1);
    @(negedge clk);
    chk({rp_i, run}, 8'h00);
    // Three cycles of the pull are already behind us here
    n = 3;
    while (rp_oe_n === 1'b0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n), 8'(SWRST_CYC));
    wait_run();
    bus(1'b1, 1'b0, ADDR_P1_DIR, 8'hFF);
    do_reset();
    end_of_test();
  end
endmodule : dio_top_bench
bind dio_top dio_chk #(.STAB_CYC(STAB_CYC)) u_dio_chk (.*);
